// File: dv/dsas_front_model.sv
// Behavioural integrator and comparator facing the sequencer's analog gates
`timescale 1ns/10ps
`default_nettype none

module dsas_front_model #(
  parameter int VIN_LEVEL  = -405,
  parameter int VREF_LEVEL = 400
) (
  input  wire logic clk,
  input  wire logic null_loop,
  input  wire logic input_gate,
  input  wire logic ref_plus,
  input  wire logic ref_minus,
  output var  logic comp_high
);
  int acc = 0;

  // Integrator holds zero in the null loop, ramps by input, then by reference
  always @(posedge clk) begin
    if (null_loop) begin
      acc <= 0;
    end else if (input_gate) begin
      acc <= acc + VIN_LEVEL;
    end else if (ref_plus) begin
      acc <= acc + VREF_LEVEL;
    end else if (ref_minus) begin
      acc <= acc - VREF_LEVEL;
    end
  end

  // High while the integrator sits on the positive-input side
  assign comp_high = (acc > 0);

endmodule

`default_nettype wire

// File: dv/dsas_sequencer_tb.sv
// Self-checking bench: one conversion of a negative input, lamp test and resets
`timescale 1ns/10ps
`default_nettype none

module dsas_sequencer_tb;
  localparam int VIN  = -405;
  localparam int VREF = 400;

  typedef struct {
    string      name;
    logic [6:0] gates;
    int         lo;
    int         hi;
  } dsas_row_t;

  logic                     clk_core;
  logic                     reset_n;
  logic                     lamp_test;
  wire logic                comp_high;
  wire dsas_pkg::dsas_gates_t gates;
  wire logic [15:0]         disp;
  dsas_row_t                rows [4];
  int                       lens [4];
  int                       len;
  int                       bad_count = 0;
  int                       tests_run = 0;

  dsas_sequencer DUT (
    .CORE_CLK               (clk_core),
    .RESET_N                (reset_n),
    .COMPARATOR_HIGH        (comp_high),
    .LAMP_TEST              (lamp_test),
    .INPUT_GATE             (gates.input_gate),
    .NULL_SHORT             (gates.null_short),
    .NULL_LOOP              (gates.null_loop),
    .LOW_TO_COMMON          (gates.low_to_common),
    .REF_PLUS_GATE          (gates.ref_plus),
    .REF_MINUS_GATE         (gates.ref_minus),
    .DEINTEGRATE_PHASE      (gates.deint),
    .MINUS_SIGN_DRIVE_N     (disp[15]),
    .HUNDREDS_DIGIT_DRIVE_N (disp[14]),
    .ONES_SEGMENT_A_N       (disp[13]),
    .ONES_SEGMENT_B_N       (disp[12]),
    .ONES_SEGMENT_C_N       (disp[11]),
    .ONES_SEGMENT_D_N       (disp[10]),
    .ONES_SEGMENT_E_N       (disp[9]),
    .ONES_SEGMENT_F_N       (disp[8]),
    .ONES_SEGMENT_G_N       (disp[7]),
    .TENS_SEGMENT_A_N       (disp[6]),
    .TENS_SEGMENT_B_N       (disp[5]),
    .TENS_SEGMENT_C_N       (disp[4]),
    .TENS_SEGMENT_D_N       (disp[3]),
    .TENS_SEGMENT_E_N       (disp[2]),
    .TENS_SEGMENT_F_N       (disp[1]),
    .TENS_SEGMENT_G_N       (disp[0])
  );

  dsas_front_model #(
    .VIN_LEVEL  (VIN),
    .VREF_LEVEL (VREF)
  ) front (
    .clk        (clk_core),
    .null_loop  (gates.null_loop),
    .input_gate (gates.input_gate),
    .ref_plus   (gates.ref_plus),
    .ref_minus  (gates.ref_minus),
    .comp_high  (comp_high)
  );

  initial begin
    clk_core = 1'b0;
    forever #50 clk_core = ~clk_core;
  end

  // Active-low segment image: minus, hundreds, ones a..g, tens a..g
  function automatic logic [15:0] expect_disp(input logic neg, input int reading);
    logic [6:0] tab [10];
    tab = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70, 7'h7F, 7'h7B};
    return {~neg, ~(reading >= 100), ~tab[reading % 10], ~tab[(reading / 10) % 10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One full cycle after the first takes 64000 cycles; the first null adds 48000
  initial begin
    repeat (130000) @(posedge clk_core);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end

  initial begin
    rows[0] = '{"first null", 7'h30, 16000, 48004};
    rows[1] = '{"integration", 7'h40, 16000, 16000};
    rows[2] = '{"deintegration", 7'h0D, 16192, 16216};
    rows[3] = '{"second null", 7'h30, 31780, 31808};
    reset_n = 1'b0;
    lamp_test = 1'b0;
    repeat (20) @(posedge clk_core);
    @(negedge clk_core);
    check("gates in reset", 32'(gates), 32'h30);
    check("display in reset", 32'(disp), 32'hFFFF);
    @(posedge clk_core);
    reset_n <= 1'b1;
    repeat (2) @(negedge clk_core);
    check("display after reset", 32'(disp), 32'(expect_disp(1'b0, 0)));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      check(rows[i].name, 32'(gates), 32'(rows[i].gates));
      len = 0;
      while (gates === rows[i].gates && len < 60000) begin
        @(negedge clk_core);
        len++;
      end
      lens[i] = len;
      check("phase length", 32'(len >= rows[i].lo && len <= rows[i].hi), 32'h1);
      $display("test %s done", rows[i].name);
    end
    check("cycle total", 32'(lens[1] + lens[2] + lens[3]), 32'h0000FA00);
    check("reading", 32'(disp), 32'(expect_disp(VIN < 0, 100 * -VIN / VREF)));
    $display("test reading done");
    @(posedge clk_core);
    lamp_test <= 1'b1;
    repeat (4) @(posedge clk_core);
    @(negedge clk_core);
    check("lamp test", 32'(disp), 32'h0);
    @(posedge clk_core);
    lamp_test <= 1'b0;
    repeat (4) @(posedge clk_core);
    @(negedge clk_core);
    check("lamp released", 32'(disp), 32'(expect_disp(VIN < 0, 100 * -VIN / VREF)));
    $display("test lamp done");
    @(posedge clk_core);
    reset_n <= 1'b0;
    @(negedge clk_core);
    check("gates on mid reset", 32'(gates), 32'h30);
    check("display on mid reset", 32'(disp), 32'hFFFF);
    repeat (2) @(posedge clk_core);
    reset_n <= 1'b1;
    repeat (2) @(negedge clk_core);
    check("display after mid reset", 32'(disp), 32'(expect_disp(1'b0, 0)));
    $display("test mid reset done");
    print_verdict();
  end

endmodule

`default_nettype wire

// File: pkg/dsas_pkg.sv
// Constants, types and segment decoding for the dual-slope converter sequencer
package dsas_pkg;

  localparam logic [1:0]  DIV_LAST         = 2'h3;
  localparam int          DIV_RATIO        = 4;
  localparam logic [13:0] AZ_MIN_PULSES    = 14'h0FA0;
  localparam logic [13:0] AZ_MAX_PULSES    = 14'h2EE0;
  localparam logic [13:0] SI_PULSES        = 14'h0FA0;
  localparam logic [13:0] RI_MAX_PULSES    = 14'h1F40;
  localparam int          CYCLE_PULSES     = 16000;
  localparam logic [5:0]  PRE_LAST         = 6'h27;
  localparam logic [3:0]  BCD_NINE         = 4'h9;

  typedef enum logic [1:0] {
    DSAS_NULL  = 2'h0,
    DSAS_INTEG = 2'h1,
    DSAS_DEINT = 2'h3
  } dsas_phase_t;

  typedef struct packed {
    logic input_gate;
    logic null_short;
    logic null_loop;
    logic low_to_common;
    logic ref_plus;
    logic ref_minus;
    logic deint;
  } dsas_gates_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic e;
    logic f;
    logic g;
  } dsas_seg_t;

  typedef struct packed {
    dsas_phase_t phase;
    logic [1:0]  div;
    logic [13:0] cnt;
    logic [5:0]  pre;
    logic [3:0]  ones;
    logic [3:0]  tens;
    logic        hund;
    logic        sign_neg;
    logic        comp_s1;
    logic        comp_s2;
    logic        lamp_s1;
    logic        lamp_s2;
    logic        disp_neg;
    logic [3:0]  disp_ones;
    logic [3:0]  disp_tens;
    logic        disp_hund;
    dsas_gates_t gates;
    logic        minus_n;
    logic        hund_n;
    dsas_seg_t   ones_seg_n;
    dsas_seg_t   tens_seg_n;
  } dsas_state_t;

  localparam dsas_gates_t GATES_RESET = 7'h30;
  localparam dsas_seg_t   SEG_OFF     = 7'h7F;
  localparam dsas_state_t STATE_RESET = '{
    phase: DSAS_NULL, div: 2'h0, cnt: 14'h0000, pre: 6'h00, ones: 4'h0, tens: 4'h0,
    hund: 1'b0, sign_neg: 1'b0, comp_s1: 1'b0, comp_s2: 1'b0, lamp_s1: 1'b0,
    lamp_s2: 1'b0, disp_neg: 1'b0, disp_ones: 4'h0, disp_tens: 4'h0, disp_hund: 1'b0,
    gates: GATES_RESET, minus_n: 1'b1, hund_n: 1'b1, ones_seg_n: SEG_OFF,
    tens_seg_n: SEG_OFF};

  // Active-high a..g pattern for one decimal digit
  function automatic dsas_seg_t dsas_decode(input logic [3:0] digit);
    dsas_seg_t s;
    s = 7'h00;
    case (digit)
      4'h0: s = 7'h7E;
      4'h1: s = 7'h30;
      4'h2: s = 7'h6D;
      4'h3: s = 7'h79;
      4'h4: s = 7'h33;
      4'h5: s = 7'h5B;
      4'h6: s = 7'h5F;
      4'h7: s = 7'h70;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h7B;
      default: s = 7'h00;
    endcase
    return s;
  endfunction

endpackage

// File: rtl/dsas_sequencer.sv
// Measurement sequencer, reading counters and LED segment drive of the converter
`timescale 1ns/10ps
`default_nettype none

module dsas_sequencer (
  input  wire logic CORE_CLK,
  input  wire logic RESET_N,
  input  wire logic COMPARATOR_HIGH,
  input  wire logic LAMP_TEST,
  output var  logic INPUT_GATE,
  output var  logic NULL_SHORT,
  output var  logic NULL_LOOP,
  output var  logic LOW_TO_COMMON,
  output var  logic REF_PLUS_GATE,
  output var  logic REF_MINUS_GATE,
  output var  logic DEINTEGRATE_PHASE,
  output var  logic MINUS_SIGN_DRIVE_N,
  output var  logic HUNDREDS_DIGIT_DRIVE_N,
  output var  logic ONES_SEGMENT_A_N,
  output var  logic ONES_SEGMENT_B_N,
  output var  logic ONES_SEGMENT_C_N,
  output var  logic ONES_SEGMENT_D_N,
  output var  logic ONES_SEGMENT_E_N,
  output var  logic ONES_SEGMENT_F_N,
  output var  logic ONES_SEGMENT_G_N,
  output var  logic TENS_SEGMENT_A_N,
  output var  logic TENS_SEGMENT_B_N,
  output var  logic TENS_SEGMENT_C_N,
  output var  logic TENS_SEGMENT_D_N,
  output var  logic TENS_SEGMENT_E_N,
  output var  logic TENS_SEGMENT_F_N,
  output var  logic TENS_SEGMENT_G_N
);

  dsas_pkg::dsas_state_t st_reg;
  dsas_pkg::dsas_state_t st_next;
  logic                  tick;
  logic                  crossed;
  logic                  finish;
  logic [13:0]           cnt_inc;

  always_comb begin
    st_next = st_reg;
    finish  = 1'b0;
    // Two-stage synchronisers for the comparator and lamp-test pins
    st_next.comp_s1 = COMPARATOR_HIGH;
    st_next.comp_s2 = st_reg.comp_s1;
    st_next.lamp_s1 = LAMP_TEST;
    st_next.lamp_s2 = st_reg.lamp_s1;
    st_next.div = st_reg.div + 2'h1;
    tick    = (st_reg.div == dsas_pkg::DIV_LAST);
    cnt_inc = st_reg.cnt + 14'h0001;
    // Integrator has crossed back once the comparator agrees with the held sign
    crossed = (st_reg.comp_s2 == st_reg.sign_neg);
    if (tick) begin
      unique case (st_reg.phase)
        dsas_pkg::DSAS_NULL: begin
          // Null starts at the pulses used by deintegration, so its end is fixed
          if (cnt_inc == dsas_pkg::AZ_MAX_PULSES) begin
            st_next.phase = dsas_pkg::DSAS_INTEG;
            st_next.cnt   = 14'h0000;
          end else begin
            st_next.cnt = cnt_inc;
          end
        end
        dsas_pkg::DSAS_INTEG: begin
          if (cnt_inc == dsas_pkg::SI_PULSES) begin
            st_next.phase    = dsas_pkg::DSAS_DEINT;
            st_next.cnt      = 14'h0000;
            st_next.sign_neg = ~st_reg.comp_s2;
            st_next.pre      = 6'h00;
            st_next.ones     = 4'h0;
            st_next.tens     = 4'h0;
            st_next.hund     = 1'b0;
          end else begin
            st_next.cnt = cnt_inc;
          end
        end
        dsas_pkg::DSAS_DEINT: begin
          // The crossing pulse is spent as well, so the cycle keeps its fixed total
          st_next.cnt = cnt_inc;
          if (crossed) begin
            finish = 1'b1;
          end else begin
            // One display count per forty pulses gives 100 x Vin / Vref
            if (st_reg.pre == dsas_pkg::PRE_LAST) begin
              st_next.pre = 6'h00;
              if (!(st_reg.hund && st_reg.tens == dsas_pkg::BCD_NINE &&
                    st_reg.ones == dsas_pkg::BCD_NINE)) begin
                if (st_reg.ones == dsas_pkg::BCD_NINE) begin
                  st_next.ones = 4'h0;
                  if (st_reg.tens == dsas_pkg::BCD_NINE) begin
                    st_next.tens = 4'h0;
                    st_next.hund = 1'b1;
                  end else begin
                    st_next.tens = st_reg.tens + 4'h1;
                  end
                end else begin
                  st_next.ones = st_reg.ones + 4'h1;
                end
              end
            end else begin
              st_next.pre = st_reg.pre + 6'h01;
            end
            if (cnt_inc == dsas_pkg::RI_MAX_PULSES) begin
              finish = 1'b1;
            end
          end
          if (finish) begin
            // Count is kept so the next null phase absorbs the unused time
            st_next.phase = dsas_pkg::DSAS_NULL;
          end
        end
        default: begin
          st_next.phase = dsas_pkg::DSAS_NULL;
          st_next.cnt   = 14'h0000;
        end
      endcase
    end
    if (finish) begin
      st_next.disp_neg  = st_reg.sign_neg;
      st_next.disp_ones = st_next.ones;
      st_next.disp_tens = st_next.tens;
      st_next.disp_hund = st_next.hund;
    end
    // Analog gate controls follow the phase being entered
    st_next.gates = '0;
    unique case (st_next.phase)
      dsas_pkg::DSAS_NULL: begin
        st_next.gates.null_short = 1'b1;
        st_next.gates.null_loop  = 1'b1;
      end
      dsas_pkg::DSAS_INTEG: begin
        st_next.gates.input_gate = 1'b1;
      end
      dsas_pkg::DSAS_DEINT: begin
        st_next.gates.low_to_common = 1'b1;
        st_next.gates.deint         = 1'b1;
        st_next.gates.ref_plus      = st_next.sign_neg;
        st_next.gates.ref_minus     = ~st_next.sign_neg;
      end
      default: begin
        st_next.gates = dsas_pkg::GATES_RESET;
      end
    endcase
    // Common-anode drive: a lit segment is a low output
    if (st_reg.lamp_s2) begin
      st_next.minus_n    = 1'b0;
      st_next.hund_n     = 1'b0;
      st_next.ones_seg_n = '0;
      st_next.tens_seg_n = '0;
    end else begin
      st_next.minus_n    = ~st_reg.disp_neg;
      st_next.hund_n     = ~st_reg.disp_hund;
      st_next.ones_seg_n = ~dsas_pkg::dsas_decode(st_reg.disp_ones);
      st_next.tens_seg_n = ~dsas_pkg::dsas_decode(st_reg.disp_tens);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= dsas_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign INPUT_GATE             = st_reg.gates.input_gate;
  assign NULL_SHORT             = st_reg.gates.null_short;
  assign NULL_LOOP              = st_reg.gates.null_loop;
  assign LOW_TO_COMMON          = st_reg.gates.low_to_common;
  assign REF_PLUS_GATE          = st_reg.gates.ref_plus;
  assign REF_MINUS_GATE         = st_reg.gates.ref_minus;
  assign DEINTEGRATE_PHASE      = st_reg.gates.deint;
  assign MINUS_SIGN_DRIVE_N     = st_reg.minus_n;
  assign HUNDREDS_DIGIT_DRIVE_N = st_reg.hund_n;
  assign ONES_SEGMENT_A_N       = st_reg.ones_seg_n.a;
  assign ONES_SEGMENT_B_N       = st_reg.ones_seg_n.b;
  assign ONES_SEGMENT_C_N       = st_reg.ones_seg_n.c;
  assign ONES_SEGMENT_D_N       = st_reg.ones_seg_n.d;
  assign ONES_SEGMENT_E_N       = st_reg.ones_seg_n.e;
  assign ONES_SEGMENT_F_N       = st_reg.ones_seg_n.f;
  assign ONES_SEGMENT_G_N       = st_reg.ones_seg_n.g;
  assign TENS_SEGMENT_A_N       = st_reg.tens_seg_n.a;
  assign TENS_SEGMENT_B_N       = st_reg.tens_seg_n.b;
  assign TENS_SEGMENT_C_N       = st_reg.tens_seg_n.c;
  assign TENS_SEGMENT_D_N       = st_reg.tens_seg_n.d;
  assign TENS_SEGMENT_E_N       = st_reg.tens_seg_n.e;
  assign TENS_SEGMENT_F_N       = st_reg.tens_seg_n.f;
  assign TENS_SEGMENT_G_N       = st_reg.tens_seg_n.g;

  // Cycle counters read only by the checks below
  localparam int AZ_MIN_CYC = int'(dsas_pkg::AZ_MIN_PULSES) * dsas_pkg::DIV_RATIO;
  localparam int AZ_MAX_CYC = int'(dsas_pkg::AZ_MAX_PULSES) * dsas_pkg::DIV_RATIO;
  localparam int SI_CYC     = int'(dsas_pkg::SI_PULSES) * dsas_pkg::DIV_RATIO;
  localparam int RI_MAX_CYC = int'(dsas_pkg::RI_MAX_PULSES) * dsas_pkg::DIV_RATIO;
  localparam int TOTAL_CYC  = dsas_pkg::CYCLE_PULSES * dsas_pkg::DIV_RATIO;

  logic [16:0] phase_cyc;
  logic [16:0] total_cyc;
  logic        cycle_seen;
  logic [7:0]  ri_pulses;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_cyc  <= 17'h00000;
      total_cyc  <= 17'h00000;
      cycle_seen <= 1'b0;
    end else begin
      phase_cyc <= (st_next.phase != st_reg.phase) ? 17'h00000 : phase_cyc + 17'h00001;
      if (st_next.phase == dsas_pkg::DSAS_NULL && st_reg.phase == dsas_pkg::DSAS_DEINT) begin
        total_cyc  <= 17'h00000;
        cycle_seen <= 1'b1;
      end else begin
        total_cyc <= total_cyc + 17'h00001;
      end
    end
  end

  assign ri_pulses = 8'(({1'b0, st_reg.disp_hund} * 8'h64) + (st_reg.disp_tens * 8'h0A)
                         + st_reg.disp_ones);

  phase_order_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $changed(st_reg.phase) |->
      (st_reg.phase == dsas_pkg::DSAS_INTEG && $past(st_reg.phase) == dsas_pkg::DSAS_NULL) ||
      (st_reg.phase == dsas_pkg::DSAS_DEINT && $past(st_reg.phase) == dsas_pkg::DSAS_INTEG) ||
      (st_reg.phase == dsas_pkg::DSAS_NULL && $past(st_reg.phase) == dsas_pkg::DSAS_DEINT))
    else $error("phase order broken");

  null_gates_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_reg.phase == dsas_pkg::DSAS_NULL |->
      NULL_SHORT && NULL_LOOP && !INPUT_GATE && !REF_PLUS_GATE && !REF_MINUS_GATE)
    else $error("null phase gates wrong");

  null_length_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ($changed(st_reg.phase) && $past(st_reg.phase) == dsas_pkg::DSAS_NULL) |->
      ($past(phase_cyc) + 17'h00001 >= 17'(AZ_MIN_CYC)) &&
      ($past(phase_cyc) + 17'h00001 <= 17'(AZ_MAX_CYC)))
    else $error("null phase length out of range");

  integ_length_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ($changed(st_reg.phase) && $past(st_reg.phase) == dsas_pkg::DSAS_INTEG) |->
      $past(phase_cyc) == 17'(SI_CYC - 1))
    else $error("integration length wrong");

  integ_gates_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_reg.phase == dsas_pkg::DSAS_INTEG |-> INPUT_GATE && !NULL_SHORT && !NULL_LOOP)
    else $error("integration gates wrong");

  sign_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (st_reg.phase == dsas_pkg::DSAS_DEINT && $past(st_reg.phase) == dsas_pkg::DSAS_INTEG) |->
      st_reg.sign_neg == !$past(st_reg.comp_s2))
    else $error("sign not latched from comparator");

  ref_polarity_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_reg.phase == dsas_pkg::DSAS_DEINT |->
      LOW_TO_COMMON && DEINTEGRATE_PHASE && (REF_PLUS_GATE == st_reg.sign_neg) &&
      (REF_MINUS_GATE != st_reg.sign_neg))
    else $error("reference polarity wrong");

  deint_bound_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_reg.phase == dsas_pkg::DSAS_DEINT |-> phase_cyc < 17'(RI_MAX_CYC))
    else $error("deintegration too long");

  full_cycle_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ($changed(st_reg.phase) && st_reg.phase == dsas_pkg::DSAS_NULL && $past(cycle_seen)) |->
      $past(total_cyc) == 17'(TOTAL_CYC - 1))
    else $error("measurement cycle not constant");

  reading_max_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ri_pulses <= 8'hC7)
    else $error("reading above full scale");

  lamp_all_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    st_reg.lamp_s2 |=> !MINUS_SIGN_DRIVE_N && !HUNDREDS_DIGIT_DRIVE_N &&
      st_reg.ones_seg_n == '0 && st_reg.tens_seg_n == '0)
    else $error("lamp test not lighting all");

  minus_sign_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !st_reg.lamp_s2 |=> MINUS_SIGN_DRIVE_N == !$past(st_reg.disp_neg))
    else $error("minus sign drive wrong");

  hundreds_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !st_reg.lamp_s2 |=> HUNDREDS_DIGIT_DRIVE_N == ($past(ri_pulses) < 8'h64))
    else $error("hundreds drive wrong");

  ones_decode_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!st_reg.lamp_s2 && st_reg.disp_ones == 4'h1) |=>
      st_reg.ones_seg_n == 7'h4F)
    else $error("ones digit one pattern wrong");

endmodule

`default_nettype wire
